// ==== design/ipg_pkg.sv ====
// Package for the prefix action decoder and IP guard block
package ipg_pkg;
    localparam int IPG_PORTS = 8;
    localparam int IPG_LEGS = 32;
    localparam int IPG_LEG_W = 5;
    localparam int IPG_NH_DEPTH = 256;
    localparam int IPG_IDX_W = 8;
    localparam int IPG_ACT_W = 62;
    localparam int IPG_V6_W = 128;
    localparam int IPG_V4_W = 32;
    localparam int IPG_PAIR_W = 2 * IPG_V6_W;
    localparam int IPG_NH_W = 18;
    localparam int IPG_MC_W = 10;
    localparam logic [1:0] IPG_T_NH_IDX = 2'h0;
    localparam logic [1:0] IPG_T_MC_IDX = 2'h1;
    localparam logic [1:0] IPG_T_INLINE = 2'h2;
    localparam logic [1:0] IPG_T_RSVD = 2'h3;
    localparam logic [7:0] IPG_ENT_RST = 8'h00;

    // Action word layouts, last field at bit 0 (packed lsb last)
    typedef struct packed {
        logic [2:0] route_group_id;
        logic [3:0] equal_cost_path_count;
        logic remap_en;
        logic [7:0] nh_index;
        logic [1:0] act_type;
    } ipg_nh_act_s;

    typedef struct packed {
        logic [7:0] mc_group_index;
        logic [1:0] act_type;
    } ipg_mc_act_s;

    typedef struct packed {
        logic entry_en;
        logic match_mac_en;
        logic match_leg_en;
        logic source_path_check_enable;
        logic [2:0] zero_mac_cpu_queue;
        logic [4:0] leg_id;
        logic [31:0] mac_low;
        logic [15:0] mac_high;
        logic [1:0] act_type;
    } ipg_inline_act_s;

    // Next-hop table entry
    typedef struct packed {
        logic [47:0] mac;
        logic [4:0] leg_id;
        logic match_leg_en;
        logic match_mac_en;
    } ipg_nh_ent_s;

    // Parsed frame fields from the pipeline
    typedef struct packed {
        logic valid;
        logic [2:0] port;
        logic ip4;
        logic ip6;
        logic v4_options;
        logic v4_csum_bad;
        logic v6_hop_opts;
        logic addr_illegal;
        logic vlan_aware;
        logic leg_match;
        logic [4:0] ingress_leg_id;
        logic [47:0] smac;
        logic [47:0] dmac;
        logic [IPG_PAIR_W-1:0] lookup_key;
        logic sip_hit;
        logic [IPG_ACT_W-1:0] sip_act;
        logic dip_hit;
        logic [IPG_ACT_W-1:0] dip_act;
    } ipg_frame_s;

    // Result toward the security rule stage
    typedef struct packed {
        logic valid;
        logic source_binding_match;
        logic dest_binding_match;
        logic route_ok;
        logic nh_valid;
        logic nh_remap;
        logic [7:0] nh_index;
        logic [3:0] equal_cost_path_count;
        logic [2:0] route_group_id;
        logic mc_valid;
        logic [7:0] mc_group_index;
        logic [4:0] egress_leg_id;
    } ipg_result_s;

    typedef enum logic [1:0] {
        IPG_ST_IDLE = 2'b00,
        IPG_ST_DONE = 2'b01
    } ipg_state_e;
endpackage

// ==== design/ipg_guard.sv ====
// Prefix action decoder, IP source/destination guard and routing eligibility
`timescale 1ns/1ps
`default_nettype none

module ipg_guard
    import ipg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire ipg_frame_s frame,
    input wire logic [IPG_PORTS-1:0] source_guard_port_enable,
    input wire logic [IPG_PORTS-1:0] dest_guard_port_enable,
    input wire logic addr_filter_en,
    input wire logic nh_wr,
    input wire logic [IPG_IDX_W-1:0] nh_wr_addr,
    input wire ipg_nh_ent_s nh_wr_data,
    input wire logic [IPG_IDX_W-1:0] remap_wr_addr,
    input wire logic [IPG_IDX_W-1:0] remap_wr_data,
    input wire logic remap_wr,
    input wire logic sticky_clr,
    output ipg_result_s result,
    output logic [IPG_PAIR_W-1:0] pair_key,
    output logic ipv4_prefix_hit_flag,
    output logic ipv6_prefix_hit_flag,
    output logic ipv4_binding_ok_flag,
    output logic ipv6_binding_ok_flag,
    output logic source_guard_fail_flag,
    output logic dest_guard_fail_flag
);
    ipg_nh_ent_s nh_tbl [IPG_NH_DEPTH];
    logic [IPG_IDX_W-1:0] remap_tbl [IPG_NH_DEPTH];
    ipg_result_s result_q, result_d;
    logic [IPG_PAIR_W-1:0] pair_key_q;
    logic v4_hit_q, v6_hit_q, v4_ok_q, v6_ok_q, sfail_q, dfail_q;
    ipg_state_e state_q;

    // Table writes
    always_ff @(posedge clk) begin
        if (nh_wr) begin
            nh_tbl[nh_wr_addr] <= nh_wr_data;
        end
        if (remap_wr) begin
            remap_tbl[remap_wr_addr] <= remap_wr_data;
        end
    end

    // Action views of both lookups
    ipg_nh_act_s s_nh, d_nh;
    ipg_mc_act_s d_mc;
    ipg_inline_act_s s_in, d_in;
    assign s_nh = ipg_nh_act_s'(frame.sip_act[IPG_NH_W-1:0]);
    assign d_nh = ipg_nh_act_s'(frame.dip_act[IPG_NH_W-1:0]);
    assign d_mc = ipg_mc_act_s'(frame.dip_act[IPG_MC_W-1:0]);
    assign s_in = ipg_inline_act_s'(frame.sip_act);
    assign d_in = ipg_inline_act_s'(frame.dip_act);

    wire [1:0] s_type = frame.sip_act[1:0];
    wire [1:0] d_type = frame.dip_act[1:0];
    wire is_ip = frame.ip4 | frame.ip6;

    // Resolve next-hop entry for a lookup, with remap and inline forms
    wire [IPG_IDX_W-1:0] s_idx = s_nh.remap_en ? remap_tbl[s_nh.nh_index] : s_nh.nh_index;
    wire [IPG_IDX_W-1:0] d_idx = d_nh.remap_en ? remap_tbl[d_nh.nh_index] : d_nh.nh_index;
    ipg_nh_ent_s s_ent, d_ent;
    assign s_ent = (s_type == IPG_T_INLINE) ?
        {s_in.mac_high, s_in.mac_low, s_in.leg_id, s_in.match_leg_en, s_in.match_mac_en} :
        nh_tbl[s_idx];
    assign d_ent = (d_type == IPG_T_INLINE) ?
        {d_in.mac_high, d_in.mac_low, d_in.leg_id, d_in.match_leg_en, d_in.match_mac_en} :
        nh_tbl[d_idx];

    // Usable hits: reserved and multicast types carry no next-hop
    wire s_usable = frame.sip_hit & (s_type == IPG_T_NH_IDX | s_type == IPG_T_INLINE);
    wire d_usable = frame.dip_hit & (d_type == IPG_T_NH_IDX | d_type == IPG_T_INLINE);

    wire s_pass = (!s_ent.match_leg_en || frame.ingress_leg_id == s_ent.leg_id) &&
        (!s_ent.match_mac_en || frame.smac == s_ent.mac);
    wire d_pass = (!d_ent.match_leg_en || frame.ingress_leg_id == d_ent.leg_id) &&
        (!d_ent.match_mac_en || frame.dmac == d_ent.mac);

    // Source guard
    wire s_en = source_guard_port_enable[frame.port];
    wire s_match = !is_ip ? 1'b1 :
        (s_usable && s_pass) ? 1'b1 : !s_en;

    // Destination guard, skipped for multicast MAC or leg match
    wire d_en = dest_guard_port_enable[frame.port];
    wire d_skip = !is_ip || frame.dmac[40] || frame.leg_match;
    wire d_match = d_skip ? 1'b1 : (d_usable && d_pass) ? 1'b1 : !d_en;

    // Routing eligibility
    wire hdr_bad = (frame.ip4 & (frame.v4_options | frame.v4_csum_bad)) |
        (frame.ip6 & frame.v6_hop_opts) | (addr_filter_en & frame.addr_illegal);
    wire route_ok = is_ip & frame.vlan_aware & frame.leg_match & !hdr_bad;

    // Result assembly, destination lookup drives forwarding
    always_comb begin
        result_d = '0;
        result_d.valid = frame.valid;
        result_d.source_binding_match = s_match;
        result_d.dest_binding_match = d_match;
        result_d.route_ok = route_ok;
        if (route_ok && frame.dip_hit) begin
            case (d_type)
                IPG_T_NH_IDX: begin
                    result_d.nh_valid = 1'b1;
                    result_d.nh_remap = d_nh.remap_en;
                    result_d.nh_index = d_nh.nh_index;
                    result_d.equal_cost_path_count = d_nh.equal_cost_path_count;
                    result_d.route_group_id = d_nh.route_group_id;
                    result_d.egress_leg_id = d_ent.leg_id;
                end
                IPG_T_MC_IDX: begin
                    result_d.mc_valid = 1'b1;
                    result_d.mc_group_index = d_mc.mc_group_index;
                end
                IPG_T_INLINE: begin
                    result_d.nh_valid = d_in.entry_en;
                    result_d.egress_leg_id = d_in.leg_id;
                end
                default: begin
                    result_d.nh_valid = 1'b0;
                end
            endcase
        end
    end

    // Pair key for multicast lookups: source low, destination high
    wire [IPG_PAIR_W-1:0] pair_d = frame.lookup_key;

    wire act = frame.valid & is_ip;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            result_q <= '0;
            pair_key_q <= '0;
            state_q <= IPG_ST_IDLE;
        end else begin
            result_q <= result_d;
            pair_key_q <= pair_d;
            state_q <= frame.valid ? IPG_ST_DONE : IPG_ST_IDLE;
        end
    end

    // Sticky flags; a set wins over a clear in the same cycle
    wire set_v4_hit = act & frame.ip4 & (s_usable | d_usable);
    wire set_v6_hit = act & frame.ip6 & (s_usable | d_usable);
    wire set_v4_ok = act & frame.ip4 & ((s_usable & s_pass) | (d_usable & d_pass & !d_skip));
    wire set_v6_ok = act & frame.ip6 & ((s_usable & s_pass) | (d_usable & d_pass & !d_skip));
    wire set_sfail = frame.valid & !s_match;
    wire set_dfail = frame.valid & !d_match;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            v4_hit_q <= 1'b0;
            v6_hit_q <= 1'b0;
            v4_ok_q <= 1'b0;
            v6_ok_q <= 1'b0;
            sfail_q <= 1'b0;
            dfail_q <= 1'b0;
        end else begin
            v4_hit_q <= set_v4_hit | (v4_hit_q & !sticky_clr);
            v6_hit_q <= set_v6_hit | (v6_hit_q & !sticky_clr);
            v4_ok_q <= set_v4_ok | (v4_ok_q & !sticky_clr);
            v6_ok_q <= set_v6_ok | (v6_ok_q & !sticky_clr);
            sfail_q <= set_sfail | (sfail_q & !sticky_clr);
            dfail_q <= set_dfail | (dfail_q & !sticky_clr);
        end
    end

    assign result = result_q;
    assign pair_key = pair_key_q;
    assign ipv4_prefix_hit_flag = v4_hit_q;
    assign ipv6_prefix_hit_flag = v6_hit_q;
    assign ipv4_binding_ok_flag = v4_ok_q;
    assign ipv6_binding_ok_flag = v6_ok_q;
    assign source_guard_fail_flag = sfail_q;
    assign dest_guard_fail_flag = dfail_q;
endmodule
`default_nettype wire

// ==== test/ipg_guard_checker.sv ====
// Assertions on the IP guard block ports
`timescale 1ns/1ps
`default_nettype none
module ipg_guard_checker
    import ipg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire ipg_frame_s frame,
    input wire logic [IPG_PORTS-1:0] source_guard_port_enable,
    input wire logic sticky_clr,
    input wire ipg_result_s result,
    input wire logic [IPG_PAIR_W-1:0] pair_key,
    input wire logic ipv4_prefix_hit_flag
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire logic fv = frame.valid;
    wire logic ip = frame.ip4 | frame.ip6;
    wire logic no_res = !(result.nh_valid || result.mc_valid);
    property p_lat; $past(rst_b) |-> result.valid == $past(fv); endproperty
    a_lat: assert property (p_lat) else $error("result not one cycle late");
    property p_key; $past(rst_b) |-> pair_key == $past(frame.lookup_key); endproperty
    a_key: assert property (p_key) else $error("pair key not copied");
    property p_nip; fv && !ip |=> result.source_binding_match && result.dest_binding_match;
    endproperty
    a_nip: assert property (p_nip) else $error("non-IP match not forced");
    property p_off;
        fv && ip && !source_guard_port_enable[frame.port] && !frame.sip_hit
        |=> result.source_binding_match;
    endproperty
    a_off: assert property (p_off) else $error("disabled port miss not matched");
    property p_vla; fv && !frame.vlan_aware |=> !result.route_ok; endproperty
    a_vla: assert property (p_vla) else $error("routed outside vlan-aware mode");
    property p_opt; fv && frame.ip4 && (frame.v4_options || frame.v4_csum_bad) |=> !result.route_ok;
    endproperty
    a_opt: assert property (p_opt) else $error("bad IPv4 header routed");
    property p_leg; fv && !frame.leg_match |=> no_res; endproperty
    a_leg: assert property (p_leg) else $error("route result without leg");
    property p_rsv; fv && frame.dip_act[1:0] == IPG_T_RSVD |=> no_res; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved action gave result");
    property p_stk; ipv4_prefix_hit_flag && !sticky_clr |=> ipv4_prefix_hit_flag; endproperty
    a_stk: assert property (p_stk) else $error("sticky flag dropped");
endmodule
bind ipg_guard ipg_guard_checker ipg_guard_checker_inst (.clk, .rst_b, .frame,
    .source_guard_port_enable, .sticky_clr, .result, .pair_key, .ipv4_prefix_hit_flag);
`default_nettype wire

// ==== test/ipg_src.sv ====
// Frame analyzer model that presents parsed frames
`timescale 1ns/1ps
`default_nettype none
module ipg_src
    import ipg_pkg::*;
(
    input wire logic clk,
    output var ipg_frame_s frame
);
    initial frame = '0;
    task automatic send(input ipg_frame_s f);
        @(posedge clk);
        frame <= f;
    endtask
    // Drops valid; stale fields turn to their inverse
    task automatic idle();
        @(posedge clk);
        frame <= {1'h0, ~frame[$bits(ipg_frame_s)-2:0]};
    endtask
endmodule
`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench for the IP guard block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
$display("wrong value %s expected %0h seen %0h", n, e, g); end end
module tb
    import ipg_pkg::*;
;
    logic clk = 1'h0;
    logic rst_b = 1'h0;
    logic [7:0] sg_en = 8'h00;
    logic [7:0] dg_en = 8'h00;
    logic afe = 1'h0;
    logic nh_wr = 1'h0;
    logic [7:0] nh_a = 8'h00;
    ipg_nh_ent_s nh_d = '0;
    logic rm_wr = 1'h0;
    logic [7:0] rm_a = 8'h00;
    logic [7:0] rm_d = 8'h00;
    logic clr = 1'h0;
    wire ipg_frame_s frame;
    ipg_result_s res;
    logic [255:0] pk;
    logic h4, h6, b4, b6, sf, df;
    ipg_frame_s f;
    int n_errors = 0;
    int n_checks = 0;
    ipg_src ipg_src_inst (.clk, .frame);
    ipg_guard ipg_guard_inst (.clk, .rst_b, .frame, .source_guard_port_enable(sg_en),
        .dest_guard_port_enable(dg_en), .addr_filter_en(afe), .nh_wr, .nh_wr_addr(nh_a),
        .nh_wr_data(nh_d), .remap_wr_addr(rm_a), .remap_wr_data(rm_d), .remap_wr(rm_wr),
        .sticky_clr(clr), .result(res), .pair_key(pk), .ipv4_prefix_hit_flag(h4),
        .ipv6_prefix_hit_flag(h6), .ipv4_binding_ok_flag(b4), .ipv6_binding_ok_flag(b6),
        .source_guard_fail_flag(sf), .dest_guard_fail_flag(df));
    initial forever #12.5 clk = ~clk;
    function automatic logic [61:0] na(input logic [7:0] i, input logic r);
        return {44'h0, 3'h1, 4'h2, r, i, 2'h0};
    endfunction
    task automatic base();
        f = '0;
        f.valid = 1'h1;
        f.ip4 = 1'h1;
        f.port = 3'h2;
        f.vlan_aware = 1'h1;
        f.ingress_leg_id = 5'h03;
    endtask
    task automatic go();
        ipg_src_inst.send(f);
        ipg_src_inst.idle();
        #1;
    endtask
    task automatic clear();
        @(posedge clk);
        clr <= 1'h1;
        @(posedge clk);
        clr <= 1'h0;
    endtask
    task automatic nhw(input logic [7:0] a, input logic [4:0] l);
        @(posedge clk);
        nh_wr <= 1'h1;
        nh_a <= a;
        nh_d <= '{mac: 48'h0, leg_id: l, match_leg_en: 1'h1, match_mac_en: 1'h0};
        @(posedge clk);
        nh_wr <= 1'h0;
    endtask
    task automatic t_guard();
        @(posedge clk);
        sg_en <= 8'h04;
        dg_en <= 8'h04;
        base(); f.ip4 = 1'h0; go();
        `CHK("non-IP", 2'h3, {res.source_binding_match, res.dest_binding_match})
        base(); go();
        `CHK("preset", 2'h0, {res.source_binding_match, res.dest_binding_match})
        `CHK("fail", 2'h3, {sf, df})
        clear(); base(); f.port = 3'h3; go();
        `CHK("other port", 4'hc, {res.source_binding_match, res.dest_binding_match, sf, df})
        base(); f.dmac[40] = 1'h1; go();
        `CHK("mc dmac", 2'h2, {sf, df})
        base(); f.leg_match = 1'h1; go();
        `CHK("leg hit", 1'h0, df)
    endtask
    task automatic t_hit();
        clear(); nhw(8'h04, 5'h03); nhw(8'h05, 5'h07);
        @(posedge clk);
        rm_wr <= 1'h1; rm_a <= 8'h05; rm_d <= 8'h04;
        @(posedge clk);
        rm_wr <= 1'h0;
        base(); f.sip_hit = 1'h1; f.sip_act = na(8'h04, 1'h0); go();
        `CHK("hit", 4'he, {res.source_binding_match, h4, b4, sf})
        f.sip_act = na(8'h05, 1'h0); go();
        `CHK("leg diff", 1'h0, res.source_binding_match)
        f.sip_act = na(8'h05, 1'h1); go();
        `CHK("remap", 1'h1, res.source_binding_match)
        f.sip_act[1:0] = IPG_T_RSVD; go();
        `CHK("reserved", 1'h0, res.source_binding_match)
        f.ip4 = 1'h0; f.ip6 = 1'h1; f.sip_act = na(8'h04, 1'h0); go();
        `CHK("v6 flags", 2'h3, {h6, b6})
    endtask
    task automatic t_route();
        nhw(8'h09, 5'h0b);
        @(posedge clk);
        afe <= 1'h1;
        base(); f.leg_match = 1'h1; f.dip_hit = 1'h1; f.dip_act = na(8'h09, 1'h0);
        f.lookup_key = {8{32'h1234abcd}} ^ 256'h1; go();
        `CHK("route", {2'h3, 8'h09, 4'h2, 3'h1}, {res.route_ok, res.nh_valid, res.nh_index,
            res.equal_cost_path_count, res.route_group_id})
        `CHK("pair key", {8{32'h1234abcd}} ^ 256'h1, pk)
        `CHK("egress leg", 6'h0b, {res.nh_remap, res.egress_leg_id})
        for (int k = 0; k < 5; k++) begin
            base(); f.leg_match = k != 3; f.dip_hit = 1'h1; f.dip_act = na(8'h09, 1'h0);
            f.vlan_aware = k != 0; f.v4_options = k == 1; f.v4_csum_bad = k == 2;
            f.addr_illegal = k == 4; go();
            `CHK("refused", 1'h0, res.nh_valid)
        end
        @(posedge clk);
        afe <= 1'h0;
        f.ip4 = 1'h0; f.ip6 = 1'h1; go();
        `CHK("no filter", 1'h1, res.nh_valid)
        f.v6_hop_opts = 1'h1; go();
        `CHK("hop opts", 1'h0, res.nh_valid)
        base(); f.leg_match = 1'h1; f.dip_hit = 1'h1; f.dip_act = {52'h0, 8'h2a, 2'h1}; go();
        `CHK("mc", 9'h12a, {res.mc_valid, res.mc_group_index})
        base(); f.leg_match = 1'h1; f.dip_hit = 1'h1;
        f.dip_act = {4'h8, 3'h0, 5'h0c, 48'h0, 2'h2}; go();
        `CHK("inline", 6'h2c, {res.nh_valid, res.egress_leg_id})
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'h1;
        @(posedge clk);
        #1;
        `CHK("reset", 7'h00, {res.valid, h4, h6, b4, b6, sf, df})
        t_guard();
        t_hit();
        t_route();
        conclude();
    end
    initial begin
        repeat (3000) @(posedge clk);
        n_errors++;
        conclude();
    end
endmodule
`default_nettype wire
